// ==== vis_buf.sv ====
// Two-entry valid/ready buffer for pixel words
`timescale 1ns/1ps
module vis_buf #(
  parameter int W = 27
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [W-1:0] mem_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : vis_buf

// ==== vis_core.sv ====
// Parallel video input capture with eye labelling and start-up indicator
`timescale 1ns/1ps
module vis_core #(
  parameter int unsigned BOOT_CYCLES = vis_pkg::BOOT_CYC,
  parameter int unsigned INIT_CYCLES = vis_pkg::INIT_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic active_low_reset_pin,
  input wire logic pix_clk,
  input wire logic [vis_pkg::PIX_W-1:0] pixel_data_bus,
  input wire logic vsync,
  input wire logic hsync,
  input wire logic data_en,
  input wire logic eye_select,
  input wire logic stereo_mode,
  output logic init_done_o,
  output logic init_done_oe_n,
  output logic ready,
  output logic [vis_pkg::CH_W-1:0] red,
  output logic [vis_pkg::CH_W-1:0] green,
  output logic [vis_pkg::CH_W-1:0] blue,
  output logic frame_start,
  output logic eye_left,
  output logic pix_valid,
  input wire logic pix_ready,
  output logic glasses_sync,
  output logic frame_pulse,
  output logic overflow
);
  localparam int BW = vis_pkg::PIX_W + 2;
  // Two-stage synchronisers; first stages read only by second stages
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic [vis_pkg::PIX_W-1:0] pd1_q;
  logic [vis_pkg::PIX_W-1:0] pd2_q;
  logic pclk_prev_q;
  logic vs_prev_q;
  logic rst_prev_q;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      pd1_q <= '0;
      pd2_q <= '0;
      pclk_prev_q <= 1'b0;
      vs_prev_q <= 1'b0;
      rst_prev_q <= 1'b0;
    end else begin
      s1_q <= {active_low_reset_pin, pix_clk, vsync, data_en, eye_select};
      s2_q <= s1_q;
      pd1_q <= pixel_data_bus;
      pd2_q <= pd1_q;
      pclk_prev_q <= s2_q[3];
      vs_prev_q <= s2_q[2];
      rst_prev_q <= s2_q[4];
    end
  end
  wire rstn_s = s2_q[4];
  wire pclk_rise = s2_q[3] && !pclk_prev_q;
  wire vs_rise = s2_q[2] && !vs_prev_q;
  wire de_s = s2_q[1];
  wire eye_s = s2_q[0];
  wire rst_release = rstn_s && !rst_prev_q;
  // Start-up sequencer
  vis_pkg::vis_state_e st_q;
  vis_pkg::vis_state_e st_d;
  logic [vis_pkg::TMR_W-1:0] tmr_q;
  wire boot_end = (tmr_q == vis_pkg::TMR_W'(BOOT_CYCLES - 1));
  wire init_end = (tmr_q == vis_pkg::TMR_W'(INIT_CYCLES - 1));
  always_comb begin
    st_d = st_q;
    case (st_q)
      vis_pkg::ST_RESET: begin
        if (rst_release) begin
          st_d = vis_pkg::ST_BOOT;
        end
      end
      vis_pkg::ST_BOOT: begin
        if (boot_end) begin
          st_d = vis_pkg::ST_INIT;
        end
      end
      vis_pkg::ST_INIT: begin
        if (init_end) begin
          st_d = vis_pkg::ST_READY;
        end
      end
      vis_pkg::ST_READY: st_d = vis_pkg::ST_READY;
      default: st_d = vis_pkg::ST_RESET;
    endcase
    if (!rstn_s) begin
      st_d = vis_pkg::ST_RESET;
    end
  end
  wire st_chg = (st_d != st_q);
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= vis_pkg::ST_RESET;
      tmr_q <= '0;
    end else begin
      st_q <= st_d;
      tmr_q <= st_chg ? '0 : tmr_q + vis_pkg::TMR_W'(1);
    end
  end
  // Open-drain style indicator: released in reset/boot, driven high then low
  wire drive_ind = (st_d == vis_pkg::ST_INIT) || (st_d == vis_pkg::ST_READY);
  wire rdy_d = (st_d == vis_pkg::ST_READY);
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      init_done_oe_n <= 1'b1;
      init_done_o <= 1'b1;
      ready <= 1'b0;
    end else begin
      init_done_oe_n <= !drive_ind;
      init_done_o <= !rdy_d;
      ready <= rdy_d;
    end
  end
  // Frame tracking; eye label latched at vsync for the following frame
  logic eye_q;
  logic in_frame_q;
  logic [vis_pkg::CNT_W-1:0] hcnt_q;
  logic [vis_pkg::CNT_W-1:0] vcnt_q;
  logic de_prev_q;
  logic sof_q;
  logic ovf_q;
  wire line_end = !de_s && de_prev_q && pclk_rise;
  wire in_area = (hcnt_q < vis_pkg::CNT_W'(vis_pkg::MAX_H)) && (vcnt_q < vis_pkg::CNT_W'(vis_pkg::MAX_V));
  // Pixels before readiness are discarded; no partial frame leaks out
  wire take = ready && in_frame_q && pclk_rise && de_s && in_area;
  wire buf_in_ready;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      eye_q <= vis_pkg::EYE_LEFT;
      in_frame_q <= 1'b0;
      hcnt_q <= '0;
      vcnt_q <= '0;
      de_prev_q <= 1'b0;
      sof_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      if (pclk_rise) begin
        de_prev_q <= de_s;
      end
      if (vs_rise) begin
        eye_q <= eye_s;
        in_frame_q <= ready;
        hcnt_q <= '0;
        vcnt_q <= '0;
        sof_q <= 1'b1;
      end else begin
        // Losing readiness ends the frame, so a restart waits for a fresh vsync
        if (!ready) begin
          in_frame_q <= 1'b0;
        end
        if (take) begin
          hcnt_q <= hcnt_q + vis_pkg::CNT_W'(1);
        end
        if (line_end) begin
          hcnt_q <= '0;
          if (vcnt_q != vis_pkg::CNT_W'(vis_pkg::MAX_V)) begin
            vcnt_q <= vcnt_q + vis_pkg::CNT_W'(1);
          end
        end
        if (take && buf_in_ready) begin
          sof_q <= 1'b0;
        end
      end
      if (take && !buf_in_ready) begin
        ovf_q <= 1'b1;
      end
    end
  end
  // Channels split as 8:8:8, red high; source already MSB-aligned and zero-filled
  wire [BW-1:0] buf_out;
  wire buf_valid;
  // Buffer pops only when the output slot takes the word, else a stalled load would repeat it
  wire slot_free = !pix_valid || pix_ready;
  vis_buf #(.W(BW)) u_buf (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_data({sof_q, eye_q, pd2_q}),
    .in_valid(take),
    .in_ready(buf_in_ready),
    .out_data(buf_out),
    .out_valid(buf_valid),
    .out_ready(slot_free)
  );
  // Output register slice; each vsync while ready yields exactly one frame pulse, a vsync before ready yields none
  wire out_load = buf_valid && slot_free;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      red <= '0;
      green <= '0;
      blue <= '0;
      frame_start <= 1'b0;
      eye_left <= 1'b0;
      pix_valid <= 1'b0;
      glasses_sync <= 1'b0;
      frame_pulse <= 1'b0;
      overflow <= 1'b0;
    end else begin
      if (out_load) begin
        red <= buf_out[23:16];
        green <= buf_out[15:8];
        blue <= buf_out[7:0];
        eye_left <= buf_out[24];
        frame_start <= buf_out[25];
        pix_valid <= 1'b1;
      end else if (pix_ready) begin
        pix_valid <= 1'b0;
      end
      frame_pulse <= vs_rise && ready;
      if (out_load && buf_out[25]) begin
        glasses_sync <= stereo_mode && (buf_out[24] == vis_pkg::EYE_LEFT);
      end
      overflow <= ovf_q;
    end
  end
endmodule : vis_core

// ==== vis_core_assertions.sv ====
// Assertions on the start-up indicator and pixel stream
`timescale 1ns/1ps
module vis_chk #(
  parameter int unsigned BOOT_CYCLES = vis_pkg::BOOT_CYC,
  parameter int unsigned INIT_CYCLES = vis_pkg::INIT_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic active_low_reset_pin,
  input wire logic init_done_o,
  input wire logic init_done_oe_n,
  input wire logic ready,
  input wire logic pix_valid,
  input wire logic pix_ready
);
  // Window allows for the two-stage pin synchroniser
  localparam int BLO = BOOT_CYCLES;
  localparam int BHI = BOOT_CYCLES + 6;
  // Cycles since the pin rose; counted, since a real boot is far too long for a delay range
  logic pin_prev_q;
  logic [31:0] rel_cnt_q;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_prev_q <= 1'b0;
      rel_cnt_q <= 32'h0;
    end else begin
      pin_prev_q <= active_low_reset_pin;
      if (!active_low_reset_pin) begin
        rel_cnt_q <= 32'h0;
      end else if (!pin_prev_q) begin
        rel_cnt_q <= 32'h1;
      end else if (rel_cnt_q != 32'hFFFFFFFF) begin
        rel_cnt_q <= rel_cnt_q + 32'h1;
      end
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_drive_hi; $fell(init_done_oe_n) ##0 init_done_o; endsequence
  sequence s_complete; !init_done_oe_n ##[0:1] ready; endsequence
  property p_rel; disable iff (1'b0) $fell(reset) |-> init_done_oe_n && !ready; endproperty
  a_rel: assert property (p_rel) else $error("driven after reset");
  property p_pin; !active_low_reset_pin [*4] |-> init_done_oe_n && !ready; endproperty
  a_pin: assert property (p_pin) else $error("driven in pin reset");
  property p_boot; s_drive_hi |-> (rel_cnt_q >= 32'(BLO)) && (rel_cnt_q <= 32'(BHI)); endproperty
  a_boot: assert property (p_boot) else $error("boot length off");
  property p_late; (rel_cnt_q == 32'(BHI)) |-> !init_done_oe_n; endproperty
  a_late: assert property (p_late) else $error("boot too long");
  property p_stay; s_drive_hi |-> init_done_o [*8]; endproperty
  a_stay: assert property (p_stay) else $error("level changed");
  property p_done; $fell(init_done_o) |-> s_complete; endproperty
  a_done: assert property (p_done) else $error("no completion");
  property p_gate; !ready |-> !pix_valid; endproperty
  a_gate: assert property (p_gate) else $error("pixel before ready");
  property p_hold; pix_valid && !pix_ready |=> pix_valid; endproperty
  a_hold: assert property (p_hold) else $error("pixel dropped");
  property p_up; ready |=> ready || !active_low_reset_pin; endproperty
  a_up: assert property (p_up) else $error("ready lost");
endmodule : vis_chk

bind vis_core vis_chk #(.BOOT_CYCLES(BOOT_CYCLES), .INIT_CYCLES(INIT_CYCLES)) u_vis_chk (.sys_clk(sys_clk),
  .reset(reset), .active_low_reset_pin(active_low_reset_pin), .init_done_o(init_done_o),
  .init_done_oe_n(init_done_oe_n), .ready(ready), .pix_valid(pix_valid), .pix_ready(pix_ready));

// ==== vis_core_tb_top.sv ====
// Self-checking bench for video capture and start-up
`timescale 1ns/1ps
module vis_core_tb_top;
  localparam int BOOT = 20;
  localparam int INIT = 100;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic active_low_reset_pin = 1'b0;
  logic stereo_mode = 1'b0;
  logic pix_ready = 1'b1;
  logic slow = 1'b0;
  logic run = 1'b1;
  logic pix_clk, vsync, hsync, data_en, eye_select, init_done_o, init_done_oe_n, ready, frame_start, eye_left;
  logic pix_valid, glasses_sync, frame_pulse, overflow;
  logic [23:0] pixel_data_bus;
  logic [7:0] red, green, blue;
  logic [26:0] got[$];
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  int n_vs = 0;
  wire done_line = init_done_oe_n ? 1'b1 : init_done_o;
  always #12.5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) pix_ready <= slow ? ~pix_ready : run;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (pix_valid === 1'b1 && pix_ready) got.push_back({frame_start, eye_left, red, green, blue});
    if (frame_pulse === 1'b1) n_vs++;
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end
  vis_src #(.EYE_LEAD(40)) u_vis_src (.sys_clk, .pix_clk, .pixel_data_bus, .vsync, .hsync, .data_en, .eye_select);
  vis_core #(.BOOT_CYCLES(BOOT), .INIT_CYCLES(INIT)) u_vis_core (.sys_clk, .reset, .active_low_reset_pin, .pix_clk,
    .pixel_data_bus, .vsync, .hsync, .data_en, .eye_select, .stereo_mode, .init_done_o, .init_done_oe_n, .ready,
    .red, .green, .blue, .frame_start, .eye_left, .pix_valid, .pix_ready, .glasses_sync, .frame_pulse, .overflow);
  task automatic check(input logic [26:0] got_v, input logic [26:0] exp);
    compares++;
    if (got_v !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got_v, exp);
    end
  endtask : check
  task automatic t_startup;
    got.delete();
    n_vs = 0;
    active_low_reset_pin = 1'b0;
    repeat (6) @(negedge sys_clk);
    check({26'h0, done_line}, 27'h1);
    check({25'h0, init_done_oe_n, ready}, 27'h2);
    active_low_reset_pin = 1'b1;
    fork
      u_vis_src.frame(1'b1, 2, 24'h123450);
    join_none
    for (n = 0; init_done_oe_n === 1'b1 && n < 500; n++) @(negedge sys_clk);
    check({26'h0, done_line}, 27'h1);
    check(27'(n >= BOOT && n <= BOOT + 6), 27'h1);
    for (n = 0; init_done_o === 1'b1 && n < 500; n++) @(negedge sys_clk);
    check(27'(n >= INIT - 4 && n <= INIT + 4), 27'h1);
    check({26'h0, ready, done_line}, 27'h2);
    check(27'(got.size()), 27'h0);
    check(27'(n_vs), 27'h0);
  endtask : t_startup
  task automatic t_stereo;
    stereo_mode = 1'b1;
    slow = 1'b1;
    u_vis_src.frame(1'b1, 3, 24'hA05010);
    check({26'h0, glasses_sync}, 27'h1);
    u_vis_src.frame(1'b0, 3, 24'h30C070);
    check({26'h0, glasses_sync}, 27'h0);
    repeat (12) @(negedge sys_clk);
    check(27'(got.size()), 27'h6);
    check(27'(n_vs), 27'h2);
    for (int i = 0; i < 6; i++) begin
      check(got[i], {i % 3 == 0, i < 3, (i < 3 ? 24'hA05010 : 24'h30C070) + 24'(24'h101010 * (i % 3))});
    end
    got.delete();
    slow = 1'b0;
  endtask : t_stereo
  task automatic t_overflow;
    stereo_mode = 1'b0;
    run = 1'b0;
    u_vis_src.frame(1'b0, 8, 24'hF0E0C0);
    check({26'h0, overflow}, 27'h1);
    run = 1'b1;
    repeat (12) @(negedge sys_clk);
    check(got[0], {2'b10, 24'hF0E0C0});
    check({26'h0, glasses_sync}, 27'h0);
  endtask : t_overflow
  task automatic conclude;
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    t_startup();
    t_stereo();
    t_overflow();
    t_startup();
    conclude();
  end
endmodule : vis_core_tb_top

// ==== vis_pkg.sv ====
// Constants for the video input and start-up block
package vis_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned PIX_W = 24;
  localparam int unsigned CH_W = 8;
  localparam int unsigned MAX_H = 1920;
  localparam int unsigned MAX_V = 1080;
  localparam int unsigned CNT_W = 12;
  localparam int unsigned BOOT_US = 1000;
  localparam int unsigned BOOT_CYC = (CLK_HZ / 1000000) * BOOT_US;
  localparam int unsigned INIT_MS = 2940;
  localparam int unsigned INIT_CYC = (CLK_HZ / 1000) * INIT_MS;
  localparam int unsigned TMR_W = 27;
  localparam logic EYE_LEFT = 1'b1;
  localparam logic EYE_RIGHT = 1'b0;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_BOOT = 2'b01,
    ST_INIT = 2'b10,
    ST_READY = 2'b11
  } vis_state_e;
endpackage : vis_pkg

// ==== vis_src_model.sv ====
// Far-side source model driving the parallel pixel port
`timescale 1ns/1ps
module vis_src #(parameter int EYE_LEAD = 40000) (
  input wire logic sys_clk,
  output logic pix_clk = 1'b0,
  output logic [vis_pkg::PIX_W-1:0] pixel_data_bus = 24'h000000,
  output logic vsync = 1'b0,
  output logic hsync = 1'b0,
  output logic data_en = 1'b0,
  output logic eye_select = 1'b0
);
  // Link clock stands still between frames; a released bus shows its inverse, never a stale word
  task automatic frame(input logic eye, input int n, input logic [23:0] px);
    eye_select = eye;
    repeat (EYE_LEAD) @(negedge sys_clk);
    vsync = 1'b1;
    repeat (4) @(negedge sys_clk);
    vsync = 1'b0;
    repeat (8) @(negedge sys_clk);
    for (int i = 0; i < n; i++) begin
      pixel_data_bus = px + 24'(24'h101010 * i);
      data_en = 1'b1;
      pix_clk = 1'b0;
      repeat (4) @(negedge sys_clk);
      pix_clk = 1'b1;
      repeat (4) @(negedge sys_clk);
    end
    data_en = 1'b0;
    pix_clk = 1'b0;
    pixel_data_bus = ~pixel_data_bus;
  endtask : frame
endmodule : vis_src
